// file: bench/lff_regs_sva.sv
// assertion checker of the led fault flag registers
`include "lff_map.vh"

module lff_regs_sva (
    input logic        clk,
    input logic        rst,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        open_flag_chan_e0,
    input logic        open_flag_chan_e1,
    input logic        open_flag_chan_e2,
    input logic        open_flag_chan_f0,
    input logic        open_flag_chan_f1,
    input logic        open_flag_chan_f2,
    input logic        open_flag_chan_g0,
    input logic        open_flag_chan_g1,
    input logic        open_flag_chan_g2,
    input logic        open_flag_chan_h0,
    input logic        open_flag_chan_h1,
    input logic        open_flag_chan_h2,
    input logic        short_flag_chan_a0,
    input logic        short_flag_chan_a1,
    input logic        short_flag_chan_a2,
    input logic        short_flag_chan_b0,
    input logic        short_flag_chan_b1,
    input logic        short_flag_chan_b2,
    input logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // expected register images
    // ------------------------------------------------------------------
    logic [7:0] ef_in, gh_in, ab_in;
    logic       rd_acc, wr_acc, a_ef, a_gh, a_ab, a_flt, a_any;
    assign ef_in = {1'b0, open_flag_chan_f2, open_flag_chan_f1,
        open_flag_chan_f0, 1'b0, open_flag_chan_e2, open_flag_chan_e1,
        open_flag_chan_e0};
    assign gh_in = {1'b0, open_flag_chan_h2, open_flag_chan_h1,
        open_flag_chan_h0, 1'b0, open_flag_chan_g2, open_flag_chan_g1,
        open_flag_chan_g0};
    assign ab_in = {1'b0, short_flag_chan_b2, short_flag_chan_b1,
        short_flag_chan_b0, 1'b0, short_flag_chan_a2, short_flag_chan_a1,
        short_flag_chan_a0};
    assign rd_acc = psel && penable && !pwrite;
    assign wr_acc = psel && penable && pwrite;
    assign a_ef = paddr == {22'h0, `LFF_ADDR_OPEN_EF};
    assign a_gh = paddr == {22'h0, `LFF_ADDR_OPEN_GH};
    assign a_ab = paddr == {22'h0, `LFF_ADDR_SHORT_AB};
    assign a_flt = a_ef || a_gh || a_ab;
    assign a_any = a_flt || paddr == {22'h0, `LFF_ADDR_IRQ_STATUS}
        || paddr == {22'h0, `LFF_ADDR_IRQ_MASK};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_ready_on_access: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    chk_ef_read_map: assert property (rd_acc && a_ef && $stable(ef_in)
        && $past(ef_in, 2) == ef_in |-> prdata == {24'h0, ef_in})
        else $error("e/f open flags read wrong");
    chk_gh_read_map: assert property (rd_acc && a_gh && $stable(gh_in)
        && $past(gh_in, 2) == gh_in |-> prdata == {24'h0, gh_in})
        else $error("g/h open flags read wrong");
    chk_ab_read_map: assert property (rd_acc && a_ab && $stable(ab_in)
        && $past(ab_in, 2) == ab_in |-> prdata == {24'h0, ab_in})
        else $error("a/b short flags read wrong");
    chk_rsvd_bits_zero: assert property (rd_acc && a_flt |->
        prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3])
        else $error("reserved fault bits not zero");
    chk_fault_wr_ok: assert property (wr_acc && a_flt |-> !pslverr)
        else $error("write to fault register flagged error");
    chk_unmapped_err: assert property (psel && penable && !a_any |->
        pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_reset_clear: assert property (disable iff (1'b0)
        rst |-> prdata == 32'h0 && !irq)
        else $error("outputs not cleared in reset");
    chk_rdata_hold: assert property (rd_acc |=> $stable(prdata))
        else $error("read data changed after access");
    cov_ef_flag: cover property (rd_acc && a_ef && prdata[6:0] != 7'h0);
    cov_fault_wr: cover property (wr_acc && a_flt);
    cov_irq_rise: cover property ($rose(irq));
endmodule

bind lff_regs lff_regs_sva chk_u (.*);

// file: bench/lff_regs_tb_top.sv
// self-checking testbench of the led fault flag registers
`include "lff_map.vh"

module lff_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        err;
    logic open_flag_chan_e0, open_flag_chan_e1, open_flag_chan_e2;
    logic open_flag_chan_f0, open_flag_chan_f1, open_flag_chan_f2;
    logic open_flag_chan_g0, open_flag_chan_g1, open_flag_chan_g2;
    logic open_flag_chan_h0, open_flag_chan_h1, open_flag_chan_h2;
    logic short_flag_chan_a0, short_flag_chan_a1, short_flag_chan_a2;
    logic short_flag_chan_b0, short_flag_chan_b1, short_flag_chan_b2;
    int          miscompares, checks_done, i;

    lff_regs dut_u (.*);

    // ------------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------------
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(logic [31:0] a, logic [31:0] exp, string name);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    function automatic logic [31:0] img(logic [5:0] v);
        return {24'h0, 1'b0, v[5:3], 1'b0, v[2:0]};
    endfunction
    task automatic set_flags(logic [17:0] v);
        @(posedge clk);
        {short_flag_chan_b2, short_flag_chan_b1, short_flag_chan_b0,
         short_flag_chan_a2, short_flag_chan_a1, short_flag_chan_a0,
         open_flag_chan_h2, open_flag_chan_h1, open_flag_chan_h0,
         open_flag_chan_g2, open_flag_chan_g1, open_flag_chan_g0,
         open_flag_chan_f2, open_flag_chan_f1, open_flag_chan_f0,
         open_flag_chan_e2, open_flag_chan_e1, open_flag_chan_e0} <= v;
        repeat (2) @(posedge clk);
    endtask
    task automatic rd_all(logic [17:0] v);
        rd_chk(`LFF_ADDR_OPEN_EF, img(v[5:0]), "open_ef");
        rd_chk(`LFF_ADDR_OPEN_GH, img(v[11:6]), "open_gh");
        rd_chk(`LFF_ADDR_SHORT_AB, img(v[17:12]), "short_ab");
    endtask
    task automatic irq_chk(logic exp);
        @(posedge clk);
        check("irq", {31'h0, irq}, {31'h0, exp});
    endtask
    task end_sim;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, watchdog and tests
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_sim;
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'b1000, 64'h0};
        pstrb = 4'hF;
        {open_flag_chan_e0, open_flag_chan_e1, open_flag_chan_e2,
         open_flag_chan_f0, open_flag_chan_f1, open_flag_chan_f2,
         open_flag_chan_g0, open_flag_chan_g1, open_flag_chan_g2,
         open_flag_chan_h0, open_flag_chan_h1, open_flag_chan_h2,
         short_flag_chan_a0, short_flag_chan_a1, short_flag_chan_a2,
         short_flag_chan_b0, short_flag_chan_b1, short_flag_chan_b2} = 18'h0;
        miscompares = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_all(18'h0);
        rd_chk(`LFF_ADDR_IRQ_STATUS, 32'h0, "irq_status");
        rd_chk(`LFF_ADDR_IRQ_MASK, 32'h0, "irq_mask");
        $display("test reset values done");
        for (i = 0; i < 18; i++) begin
            set_flags(18'h1 << i);
            rd_all(18'h1 << i);
        end
        $display("test flag mapping done");
        set_flags(18'h2AAAA);
        apb(1'b1, `LFF_ADDR_OPEN_EF, 32'hFFFFFFFF);
        check("wr_err_ef", {31'h0, err}, 32'h0);
        apb(1'b1, `LFF_ADDR_OPEN_GH, 32'hFFFFFFFF);
        check("wr_err_gh", {31'h0, err}, 32'h0);
        apb(1'b1, `LFF_ADDR_SHORT_AB, 32'hFFFFFFFF);
        check("wr_err_ab", {31'h0, err}, 32'h0);
        rd_all(18'h2AAAA);
        $display("test write ignored done");
        apb(1'b0, 32'h00000400, 32'h0);
        check("unmapped_rd", {err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 32'h00000100, 32'hFFFFFFFF);
        check("unmapped_wr", {31'h0, err}, 32'h1);
        $display("test unmapped done");
        rd_chk(`LFF_ADDR_IRQ_STATUS, 32'h00777777, "status_all");
        irq_chk(1'b0);
        apb(1'b1, `LFF_ADDR_IRQ_MASK, 32'h1);
        irq_chk(1'b1);
        rd_chk(`LFF_ADDR_IRQ_MASK, 32'h1, "mask_rb");
        pstrb <= 4'h2;
        apb(1'b1, `LFF_ADDR_IRQ_MASK, 32'h00FFFFFF);
        pstrb <= 4'hF;
        rd_chk(`LFF_ADDR_IRQ_MASK, 32'h0000FF01, "mask_lane");
        set_flags(18'h0);
        apb(1'b1, `LFF_ADDR_IRQ_STATUS, 32'h00777777);
        irq_chk(1'b0);
        rd_chk(`LFF_ADDR_IRQ_STATUS, 32'h0, "status_clr");
        set_flags(18'h1);
        irq_chk(1'b1);
        set_flags(18'h3);
        rd_chk(`LFF_ADDR_IRQ_STATUS, 32'h3, "status_two");
        apb(1'b1, `LFF_ADDR_IRQ_STATUS, 32'h1);
        irq_chk(1'b0);
        rd_chk(`LFF_ADDR_IRQ_STATUS, 32'h2, "status_w1c");
        $display("test interrupt done");
        end_sim;
    end
endmodule

// file: src/lff_apb_port.v
// apb slave handshake and address decode of the led fault flag block
`include "lff_map.vh"

module lff_apb_port (
    psel,
    penable,
    pwrite,
    paddr,
    pready,
    setup,
    commit_wr,
    sel,
    hit
);
    input  wire                       psel;
    input  wire                       penable;
    input  wire                       pwrite;
    input  wire [`LFF_DATA_W-1:0]     paddr;
    output wire                       pready;
    output wire                       setup;
    output wire                       commit_wr;
    output wire [`LFF_SEL_W-1:0]      sel;
    output wire                       hit;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function [`LFF_SEL_W-1:0] decode;
        input [`LFF_DATA_W-1:0] addr;
        reg   [`LFF_SEL_W-1:0]  s;
        begin
            s = {`LFF_SEL_W{1'b0}};
            if (addr[`LFF_DATA_W-1:`LFF_ADDR_W] == 22'h000000) begin
                case (addr[`LFF_ADDR_W-1:0])
                    `LFF_ADDR_OPEN_EF:    s[`LFF_SEL_OPEN_EF]    = 1'b1;
                    `LFF_ADDR_OPEN_GH:    s[`LFF_SEL_OPEN_GH]    = 1'b1;
                    `LFF_ADDR_SHORT_AB:   s[`LFF_SEL_SHORT_AB]   = 1'b1;
                    `LFF_ADDR_IRQ_STATUS: s[`LFF_SEL_IRQ_STATUS] = 1'b1;
                    `LFF_ADDR_IRQ_MASK:   s[`LFF_SEL_IRQ_MASK]   = 1'b1;
                    default:              s = {`LFF_SEL_W{1'b0}};
                endcase
            end
            decode = s;
        end
    endfunction

    // ------------------------------------------------------------------
    // handshake: no wait state, access ends in its first cycle
    // ------------------------------------------------------------------
    assign sel       = decode(paddr);
    assign hit       = |sel;
    assign setup     = psel & ~penable;
    // answer registered at setup, so access phase can complete at once
    assign pready    = psel & penable;
    assign commit_wr = psel & penable & pwrite;
endmodule

// file: src/lff_map.vh
// register map and field constants of the led fault flag block
`ifndef LFF_MAP_VH
`define LFF_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define LFF_IDX_OPEN_EF     8'hA9
`define LFF_IDX_OPEN_GH     8'hAA
`define LFF_IDX_SHORT_AB    8'hAB
`define LFF_IDX_IRQ_STATUS  8'hB0
`define LFF_IDX_IRQ_MASK    8'hB1

// ----------------------------------------------------------------------
// byte addresses on the apb bus
// ----------------------------------------------------------------------
`define LFF_ADDR_W          10
`define LFF_ADDR_OPEN_EF    10'h2A4
`define LFF_ADDR_OPEN_GH    10'h2A8
`define LFF_ADDR_SHORT_AB   10'h2AC
`define LFF_ADDR_IRQ_STATUS 10'h2C0
`define LFF_ADDR_IRQ_MASK   10'h2C4

// ----------------------------------------------------------------------
// register select one-hot positions
// ----------------------------------------------------------------------
`define LFF_SEL_W           5
`define LFF_SEL_OPEN_EF     0
`define LFF_SEL_OPEN_GH     1
`define LFF_SEL_SHORT_AB    2
`define LFF_SEL_IRQ_STATUS  3
`define LFF_SEL_IRQ_MASK    4

// ----------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------
`define LFF_FLAG_W          8
`define LFF_HI_LSB          4
`define LFF_LO_LSB          0
`define LFF_RSVD_HI_BIT     7
`define LFF_RSVD_LO_BIT     3
`define LFF_FLAG_RESET      8'h00
`define LFF_IRQ_W           24
`define LFF_IRQ_EF_LSB      0
`define LFF_IRQ_GH_LSB      8
`define LFF_IRQ_AB_LSB      16
`define LFF_IRQ_RESET       24'h000000
`define LFF_DATA_W          32

`endif

// file: src/lff_regs.v
// led fault flag registers with apb slave and fault interrupt
//
// Overview of operation
// - e/f open-fault register at index A9h, read-only, reset zero, bits 7,3 zero
// - g/h open-fault register at index AAh, read-only, reset zero, bits 7,3 zero
// - a/b short-fault register at index ABh, read-only, reset zero, bits 7,3 zero
// - e/f register: bits 6..4 channel f outputs 2..0, bits 2..0 e
// - g/h register: bits 6..4 channel h outputs 2..0, bits 2..0 g
// - a/b register: bits 6..4 channel b outputs 2..0, bits 2..0 a
// - open flag reads one when an open fault is detected, else zero
// - short flag reads one when a short fault is detected, else zero
//
// Decided for this implementation: register access over APB.
`include "lff_map.vh"

module lff_regs (
    clk,
    rst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    open_flag_chan_e0,
    open_flag_chan_e1,
    open_flag_chan_e2,
    open_flag_chan_f0,
    open_flag_chan_f1,
    open_flag_chan_f2,
    open_flag_chan_g0,
    open_flag_chan_g1,
    open_flag_chan_g2,
    open_flag_chan_h0,
    open_flag_chan_h1,
    open_flag_chan_h2,
    short_flag_chan_a0,
    short_flag_chan_a1,
    short_flag_chan_a2,
    short_flag_chan_b0,
    short_flag_chan_b1,
    short_flag_chan_b2,
    irq
);
    input  wire                       clk;
    input  wire                       rst;
    input  wire                       psel;
    input  wire                       penable;
    input  wire                       pwrite;
    input  wire [`LFF_DATA_W-1:0]     paddr;
    input  wire [`LFF_DATA_W-1:0]     pwdata;
    input  wire [3:0]                 pstrb;
    output wire [`LFF_DATA_W-1:0]     prdata;
    output wire                       pready;
    output wire                       pslverr;
    input  wire                       open_flag_chan_e0;
    input  wire                       open_flag_chan_e1;
    input  wire                       open_flag_chan_e2;
    input  wire                       open_flag_chan_f0;
    input  wire                       open_flag_chan_f1;
    input  wire                       open_flag_chan_f2;
    input  wire                       open_flag_chan_g0;
    input  wire                       open_flag_chan_g1;
    input  wire                       open_flag_chan_g2;
    input  wire                       open_flag_chan_h0;
    input  wire                       open_flag_chan_h1;
    input  wire                       open_flag_chan_h2;
    input  wire                       short_flag_chan_a0;
    input  wire                       short_flag_chan_a1;
    input  wire                       short_flag_chan_a2;
    input  wire                       short_flag_chan_b0;
    input  wire                       short_flag_chan_b1;
    input  wire                       short_flag_chan_b2;
    output wire                       irq;

    // ------------------------------------------------------------------
    // field packing
    // ------------------------------------------------------------------
    // two three-output channels into one byte, reserved bits zero
    function [`LFF_FLAG_W-1:0] pack_pair;
        input [2:0] hi_chan;
        input [2:0] lo_chan;
        reg   [`LFF_FLAG_W-1:0] b;
        begin
            b = `LFF_FLAG_RESET;
            b[`LFF_HI_LSB+2:`LFF_HI_LSB] = hi_chan;
            b[`LFF_LO_LSB+2:`LFF_LO_LSB] = lo_chan;
            b[`LFF_RSVD_HI_BIT]          = 1'b0;
            b[`LFF_RSVD_LO_BIT]          = 1'b0;
            pack_pair = b;
        end
    endfunction

    // byte-lane merge of a write into a register image
    function [`LFF_IRQ_W-1:0] lane_merge;
        input [`LFF_IRQ_W-1:0]  old_val;
        input [`LFF_DATA_W-1:0] wdata;
        input [3:0]             strb;
        reg   [`LFF_IRQ_W-1:0]  v;
        integer                 i;
        begin
            v = old_val;
            for (i = 0; i < 3; i = i + 1) begin
                if (strb[i]) begin
                    v[i*8 +: 8] = wdata[i*8 +: 8];
                end
            end
            lane_merge = v;
        end
    endfunction

    // ------------------------------------------------------------------
    // bus port
    // ------------------------------------------------------------------
    wire [`LFF_SEL_W-1:0] sel;
    wire                  hit;
    wire                  setup;
    wire                  commit_wr;

    lff_apb_port u_port (
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pready    (pready),
        .setup     (setup),
        .commit_wr (commit_wr),
        .sel       (sel),
        .hit       (hit)
    );

    // ------------------------------------------------------------------
    // fault flag images
    // ------------------------------------------------------------------
    wire [`LFF_FLAG_W-1:0] open_ef_nxt;
    wire [`LFF_FLAG_W-1:0] open_gh_nxt;
    wire [`LFF_FLAG_W-1:0] short_ab_nxt;

    // f in upper half, e in lower half
    assign open_ef_nxt = pack_pair(
        {open_flag_chan_f2, open_flag_chan_f1, open_flag_chan_f0},
        {open_flag_chan_e2, open_flag_chan_e1, open_flag_chan_e0});
    // h in upper half, g in lower half
    assign open_gh_nxt = pack_pair(
        {open_flag_chan_h2, open_flag_chan_h1, open_flag_chan_h0},
        {open_flag_chan_g2, open_flag_chan_g1, open_flag_chan_g0});
    // b in upper half, a in lower half
    assign short_ab_nxt = pack_pair(
        {short_flag_chan_b2, short_flag_chan_b1, short_flag_chan_b0},
        {short_flag_chan_a2, short_flag_chan_a1, short_flag_chan_a0});

    reg [`LFF_FLAG_W-1:0] open_fault_flags_ef_r;
    reg [`LFF_FLAG_W-1:0] open_fault_flags_gh_r;
    reg [`LFF_FLAG_W-1:0] short_fault_flags_ab_r;

    // images follow the detectors only; bus writes never reach them
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            open_fault_flags_ef_r  <= `LFF_FLAG_RESET;
            open_fault_flags_gh_r  <= `LFF_FLAG_RESET;
            short_fault_flags_ab_r <= `LFF_FLAG_RESET;
        end else begin
            open_fault_flags_ef_r  <= open_ef_nxt;
            open_fault_flags_gh_r  <= open_gh_nxt;
            short_fault_flags_ab_r <= short_ab_nxt;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    wire [`LFF_IRQ_W-1:0] new_fault;
    wire [`LFF_IRQ_W-1:0] status_clr;
    wire [`LFF_IRQ_W-1:0] irq_status_nxt;
    wire [`LFF_IRQ_W-1:0] irq_mask_nxt;
    reg  [`LFF_IRQ_W-1:0] irq_status_r;
    reg  [`LFF_IRQ_W-1:0] irq_mask_r;

    // a flag going from clear to set is a new fault
    assign new_fault = {short_ab_nxt & ~short_fault_flags_ab_r,
                        open_gh_nxt  & ~open_fault_flags_gh_r,
                        open_ef_nxt  & ~open_fault_flags_ef_r};

    // write one to clear, byte lanes honoured
    assign status_clr = (commit_wr && sel[`LFF_SEL_IRQ_STATUS]) ?
                        lane_merge({`LFF_IRQ_W{1'b0}}, pwdata, pstrb) :
                        {`LFF_IRQ_W{1'b0}};

    // set wins over a clear in the same cycle
    assign irq_status_nxt = (irq_status_r & ~status_clr) | new_fault;

    assign irq_mask_nxt = (commit_wr && sel[`LFF_SEL_IRQ_MASK]) ?
                          lane_merge(irq_mask_r, pwdata, pstrb) :
                          irq_mask_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_status_r <= `LFF_IRQ_RESET;
            irq_mask_r   <= `LFF_IRQ_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
            irq_mask_r   <= irq_mask_nxt;
        end
    end

    // level output, high while any unmasked event is pending
    assign irq = |(irq_status_r & irq_mask_r);

    // ------------------------------------------------------------------
    // read data and error answer
    // ------------------------------------------------------------------
    reg  [`LFF_DATA_W-1:0] rd_mux;
    reg  [`LFF_DATA_W-1:0] prdata_r;
    reg                    pslverr_r;

    always @* begin
        rd_mux = {`LFF_DATA_W{1'b0}};
        case (sel)
            (5'h01 << `LFF_SEL_OPEN_EF):
                rd_mux[`LFF_FLAG_W-1:0] = open_fault_flags_ef_r;
            (5'h01 << `LFF_SEL_OPEN_GH):
                rd_mux[`LFF_FLAG_W-1:0] = open_fault_flags_gh_r;
            (5'h01 << `LFF_SEL_SHORT_AB):
                rd_mux[`LFF_FLAG_W-1:0] = short_fault_flags_ab_r;
            (5'h01 << `LFF_SEL_IRQ_STATUS):
                rd_mux[`LFF_IRQ_W-1:0] = irq_status_r;
            (5'h01 << `LFF_SEL_IRQ_MASK):
                rd_mux[`LFF_IRQ_W-1:0] = irq_mask_r;
            default:
                rd_mux = {`LFF_DATA_W{1'b0}};
        endcase
    end

    // answer captured in the setup cycle and held through access
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_r  <= {`LFF_DATA_W{1'b0}};
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= pwrite ? {`LFF_DATA_W{1'b0}} : rd_mux;
            pslverr_r <= ~hit;
        end
    end

    assign prdata  = prdata_r;
    // error only inside the access phase, as apb expects
    assign pslverr = pslverr_r & pready;
endmodule
